/* hw/ist_pkg.sv */
// Package with register map, reset values and carrier types of the timer.
`default_nettype none
package ist_pkg;
    localparam int IST_CHANNELS = 8;
    localparam int IST_WAVE_CHANNELS = 7;
    localparam int IST_CNT_W = 16;
    localparam int IST_SUB_DIV = 4;

    // Byte addresses of the registers.
    localparam logic [7:0] IST_OFS_START = 8'h00;
    localparam logic [7:0] IST_OFS_STOP = 8'h04;
    localparam logic [7:0] IST_OFS_ENSTAT = 8'h08;
    localparam logic [7:0] IST_OFS_CLKSEL = 8'h0C;
    localparam logic [7:0] IST_OFS_MODE = 8'h10;
    localparam logic [7:0] IST_OFS_DIVA = 8'h14;
    localparam logic [7:0] IST_OFS_DIVB = 8'h18;
    localparam logic [7:0] IST_OFS_ISC = 8'h1C;
    localparam logic [7:0] IST_OFS_RELOAD0 = 8'h20;
    localparam logic [7:0] IST_OFS_COUNTER0 = 8'h40;
    localparam logic [7:0] IST_OFS_IRQSTAT = 8'h60;
    localparam logic [7:0] IST_OFS_IRQCLR = 8'h64;
    localparam logic [7:0] IST_OFS_IRQEN = 8'h68;
    localparam logic [7:0] IST_OFS_WAVE = 8'h6C;
    localparam logic [7:0] IST_OFS_EDGE = 8'h70;

    localparam logic [15:0] IST_RELOAD_RST = 16'h0000;
    localparam logic [15:0] IST_DIV_RST = 16'h0000;
    localparam logic [1:0] IST_SUB_CNT_LAST = 2'(IST_SUB_DIV - 1);

    typedef enum logic [1:0]
    {
        IST_CLK_A,
        IST_CLK_B,
        IST_CLK_SUB,
        IST_CLK_OFF
    } ist_clksel_t;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ist_apb_req_t;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ist_apb_rsp_t;
endpackage
`default_nettype wire

/* hw/ist_interval_timer.sv */
// Eight-channel interval timer with square-wave outputs behind APB.
//
// Functional notes
// (R1) Interrupt period is count clock period times reload value plus one.
// (R2) Count clock is prescaled clock A, B, or subsystem tick divided by four.
// (R3) Software stops all channels via stop register before changing system clock.
// (R4) Wave output toggles exactly when the period interrupt fires.
// (R5) Wave period is twice the interrupt period, giving 50 percent duty.
// (R6) Loaded counter decrements by one on each count clock tick.
// (R7) After start trigger, counter loads reload value on the next tick.
// (R8) Start load fires interrupt and toggle only if start select bit set.
// (R9) Zero counter at next tick fires interrupt, toggles and reloads, repeating.
// (R10) Reload writes accepted anytime; they take effect at the next reload.
// (R11) Eight counting channels; only channels 0 to 6 drive wave outputs.
// (R12) Input edges sampled on operation clock give one-cycle rise/fall triggers; here sampled only on the channel count tick.
// (R13) Channel 7 input comes from the input switch control selection.
// (R14) Channels run independently; no group constraints cross channels.
// (R15) Count clocks are one-cycle enables in the peripheral clock domain.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ist_interval_timer
    import ist_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ist_pkg::ist_apb_req_t apbReq,
    output var ist_pkg::ist_apb_rsp_t apbRsp,
    input wire logic subClkTick,
    input wire logic [6:0] channelInputPin,
    input wire logic linRxIn,
    input wire logic auxInput7,
    output logic [6:0] channelWaveOutput,
    output logic [7:0] edgeRiseTrig,
    output logic [7:0] edgeFallTrig,
    output logic irqOut
);
    typedef struct packed
    {
        logic [15:0] divA;
        logic [15:0] divB;
        logic [15:0] presCntA;
        logic [15:0] presCntB;
        logic tickA;
        logic tickB;
        logic [1:0] subCnt;
        logic tickSub;
        logic [7:0][1:0] clkSel;
        logic [7:0] startIrqSel;
        logic [7:0] cntEn;
        logic [7:0] startPend;
        logic [7:0][15:0] counter;
        logic [7:0][15:0] reload;
        logic [7:0] irqStat;
        logic [7:0] irqEn;
        logic [6:0] wave;
        logic iscSel;
        logic [7:0] inSync1;
        logic [7:0] inSync2;
        logic [7:0] inSamp;
        logic [7:0] rise;
        logic [7:0] fall;
        logic irq;
        ist_apb_rsp_t rsp;
    } ist_state_t;

    ist_state_t st_reg;
    ist_state_t st_next;
    logic [7:0] chTick;
    logic [7:0] chEvt;
    logic [7:0] rawIn;
    logic wrAcc;
    logic rdAcc;
    logic [7:0] irqClr;

    // Channel 7 has no pin of its own. // (R13)
    assign rawIn = {st_reg.iscSel ? auxInput7 : linRxIn, channelInputPin};

    // A write commits at the edge where the master sees pready high.
    assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite
        && st_reg.rsp.pready;
    assign rdAcc = apbReq.psel && apbReq.penable && !st_reg.rsp.pready;

    function automatic logic [31:0] readMux(input ist_state_t s,
        input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a >= IST_OFS_RELOAD0 && a < IST_OFS_COUNTER0)
        begin
            d[15:0] = s.reload[a[4:2]];
        end
        else if (a >= IST_OFS_COUNTER0 && a < IST_OFS_IRQSTAT)
        begin
            d[15:0] = s.counter[a[4:2]];
        end
        else
        begin
            case (a)
                IST_OFS_ENSTAT: d[7:0] = s.cntEn;
                IST_OFS_CLKSEL: d[15:0] = s.clkSel;
                IST_OFS_MODE: d[7:0] = s.startIrqSel;
                IST_OFS_DIVA: d[15:0] = s.divA;
                IST_OFS_DIVB: d[15:0] = s.divB;
                IST_OFS_ISC: d[0] = s.iscSel;
                IST_OFS_IRQSTAT: d[7:0] = s.irqStat;
                IST_OFS_IRQEN: d[7:0] = s.irqEn;
                IST_OFS_WAVE: d[6:0] = s.wave;
                IST_OFS_EDGE: d[7:0] = s.inSamp;
                default: d = 32'h0000_0000;
            endcase
        end
        return d;
    endfunction

    function automatic logic addrMapped(input logic [7:0] a);
        logic ok;
        ok = (a[1:0] == 2'b00) && (a <= IST_OFS_EDGE);
        return ok;
    endfunction

    always_comb
    begin
        st_next = st_reg;
        chTick = 8'h00;
        chEvt = 8'h00;
        irqClr = 8'h00;

        // Prescalers emit single-cycle enables, never derived clocks. // (R15)
        st_next.tickA = 1'b0;
        st_next.tickB = 1'b0;
        st_next.tickSub = 1'b0;
        if (st_reg.presCntA >= st_reg.divA)
        begin
            st_next.presCntA = 16'h0000;
            st_next.tickA = 1'b1;
        end
        else
        begin
            st_next.presCntA = st_reg.presCntA + 16'h0001;
        end
        if (st_reg.presCntB >= st_reg.divB)
        begin
            st_next.presCntB = 16'h0000;
            st_next.tickB = 1'b1;
        end
        else
        begin
            st_next.presCntB = st_reg.presCntB + 16'h0001;
        end
        // Subsystem tick divided by four, independent of clk_sys rate. // (R2)
        if (subClkTick)
        begin
            st_next.subCnt = st_reg.subCnt + 2'b01;
            st_next.tickSub = (st_reg.subCnt == IST_SUB_CNT_LAST);
        end

        // APB slave: one wait state, then the response stands one cycle.
        st_next.rsp.pready = 1'b0;
        st_next.rsp.pslverr = 1'b0;
        if (rdAcc)
        begin
            st_next.rsp.pready = 1'b1;
            st_next.rsp.pslverr = !addrMapped(apbReq.paddr);
            st_next.rsp.prdata = apbReq.pwrite ? 32'h0000_0000
                : readMux(st_reg, apbReq.paddr);
        end

        if (wrAcc && addrMapped(apbReq.paddr))
        begin
            if (apbReq.paddr >= IST_OFS_RELOAD0
                && apbReq.paddr < IST_OFS_COUNTER0)
            begin
                // Only the reload copy changes; the period in flight keeps
                // running on the counter. // (R10)
                st_next.reload[apbReq.paddr[4:2]] = apbReq.pwdata[15:0];
            end
            case (apbReq.paddr)
                IST_OFS_START:
                begin
                    st_next.cntEn = st_reg.cntEn | apbReq.pwdata[7:0];
                    st_next.startPend = st_reg.startPend
                        | apbReq.pwdata[7:0];
                end
                IST_OFS_STOP:
                begin
                    // Writing all ones halts every channel at once. // (R3)
                    st_next.cntEn = st_reg.cntEn & ~apbReq.pwdata[7:0];
                    st_next.startPend = st_reg.startPend
                        & ~apbReq.pwdata[7:0];
                end
                IST_OFS_CLKSEL: st_next.clkSel = apbReq.pwdata[15:0];
                IST_OFS_MODE: st_next.startIrqSel = apbReq.pwdata[7:0];
                IST_OFS_DIVA: st_next.divA = apbReq.pwdata[15:0];
                IST_OFS_DIVB: st_next.divB = apbReq.pwdata[15:0];
                IST_OFS_ISC: st_next.iscSel = apbReq.pwdata[0];
                IST_OFS_IRQCLR: irqClr = apbReq.pwdata[7:0];
                IST_OFS_IRQEN: st_next.irqEn = apbReq.pwdata[7:0];
                default:
                begin
                end
            endcase
        end

        // Each channel runs alone; nothing couples one to another. // (R14)
        for (int n = 0; n < IST_CHANNELS; n++)
        begin
            case (ist_clksel_t'(st_reg.clkSel[n]))
                IST_CLK_A: chTick[n] = st_reg.tickA;
                IST_CLK_B: chTick[n] = st_reg.tickB;
                IST_CLK_SUB: chTick[n] = st_reg.tickSub; // (R2)
                default: chTick[n] = 1'b0;
            endcase
            if (chTick[n] && st_reg.startPend[n] && st_next.cntEn[n])
            begin
                st_next.counter[n] = st_reg.reload[n]; // (R7)
                st_next.startPend[n] = 1'b0;
                chEvt[n] = st_reg.startIrqSel[n]; // (R8)
            end
            else if (chTick[n] && st_reg.cntEn[n] && st_next.cntEn[n])
            begin
                if (st_reg.counter[n] == 16'h0000)
                begin
                    // Reload-plus-one ticks per period. // (R1) (R9)
                    st_next.counter[n] = st_reg.reload[n];
                    chEvt[n] = 1'b1;
                end
                else
                begin
                    st_next.counter[n] = st_reg.counter[n] - 16'h0001; // (R6)
                end
            end

            // Input synchroniser, then sampling on the channel tick. // (R12)
            st_next.inSync1[n] = rawIn[n];
            st_next.inSync2[n] = st_reg.inSync1[n];
            st_next.rise[n] = 1'b0;
            st_next.fall[n] = 1'b0;
            if (chTick[n])
            begin
                st_next.inSamp[n] = st_reg.inSync2[n];
                st_next.rise[n] = st_reg.inSync2[n] && !st_reg.inSamp[n];
                st_next.fall[n] = !st_reg.inSync2[n] && st_reg.inSamp[n];
            end
        end

        // Only the low seven channels own an output pin. // (R11)
        for (int k = 0; k < IST_WAVE_CHANNELS; k++)
        begin
            if (chEvt[k])
            begin
                st_next.wave[k] = !st_reg.wave[k]; // (R4) (R5)
            end
        end

        // A new event beats a clear in the same cycle.
        st_next.irqStat = (st_reg.irqStat & ~irqClr) | chEvt; // (R1)
        st_next.irq = |(st_next.irqStat & st_next.irqEn);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign apbRsp = st_reg.rsp;
    assign channelWaveOutput = st_reg.wave;
    assign edgeRiseTrig = st_reg.rise;
    assign edgeFallTrig = st_reg.fall;
    assign irqOut = st_reg.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_irq_period: assert property (chEvt[0] |=> st_reg.irqStat[0]) // (R1)
        else $error("Channel 0 event did not set its status bit.");
    a_wave_toggle: assert property ( // (R4)
        chEvt[1] |=> channelWaveOutput[1] != $past(channelWaveOutput[1]))
        else $error("Wave output did not toggle on the event.");
    a_wave_quiet: assert property ( // (R5)
        !chEvt[1] |=> channelWaveOutput[1] == $past(channelWaveOutput[1]))
        else $error("Wave output changed without an event.");
    a_count_down: assert property ( // (R6)
        chTick[1] && st_reg.cntEn[1] && !st_reg.startPend[1]
        && st_reg.counter[1] != 16'h0000 && !wrAcc
        |=> st_reg.counter[1] == $past(st_reg.counter[1]) - 16'h0001)
        else $error("Counter did not decrement by one.");
    a_start_load: assert property ( // (R7)
        chTick[3] && st_reg.startPend[3] && !wrAcc
        |=> st_reg.counter[3] == $past(st_reg.reload[3])
        && !st_reg.startPend[3])
        else $error("Start did not load the reload value.");
    a_start_silent: assert property ( // (R8)
        chTick[3] && st_reg.startPend[3] && !st_reg.startIrqSel[3]
        |-> !chEvt[3])
        else $error("Start load raised an event while silent.");
    a_zero_reload: assert property ( // (R9)
        chTick[4] && st_reg.cntEn[4] && !st_reg.startPend[4]
        && st_reg.counter[4] == 16'h0000 && !wrAcc
        |-> chEvt[4] ##1 st_reg.counter[4] == $past(st_reg.reload[4]))
        else $error("Zero count did not reload with an event.");
    a_stop_all: assert property ( // (R3)
        wrAcc && apbReq.paddr == IST_OFS_STOP
        && apbReq.pwdata[7:0] == 8'hFF |=> st_reg.cntEn == 8'h00)
        else $error("Stop of all channels left one running.");
    a_edge_pulse: assert property ( // (R12)
        edgeRiseTrig[2] |=> !edgeRiseTrig[2] && !edgeFallTrig[2])
        else $error("Edge trigger lasted more than one cycle.");
    a_irq_level: assert property ( // (R1)
        chEvt[0] && st_reg.irqEn[0] && !wrAcc |=> irqOut)
        else $error("Enabled event did not raise the interrupt output.");
endmodule
`default_nettype wire

/* verification/ist_interval_timer_tb.sv */
// Self-checking testbench for the eight-channel interval timer.
`timescale 1ns/1ps
`default_nettype none
module ist_interval_timer_tb;
    import ist_pkg::*;
    logic clk_sys;
    logic rst_n;
    ist_apb_req_t apbReq;
    ist_apb_rsp_t apbRsp;
    logic subClkTick = 1'b0;
    logic [6:0] channelInputPin;
    logic linRxIn;
    logic auxInput7;
    logic [6:0] channelWaveOutput;
    logic [7:0] edgeRiseTrig;
    logic [7:0] edgeFallTrig;
    logic irqOut;
    int n_errors;
    int n_checks;
    int cyc;
    int lastTog[7];
    int nRise[8];
    int nFall[8];
    int n;
    int gap;

    ist_interval_timer dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .subClkTick(subClkTick),
        .channelInputPin(channelInputPin),
        .linRxIn(linRxIn),
        .auxInput7(auxInput7),
        .channelWaveOutput(channelWaveOutput),
        .edgeRiseTrig(edgeRiseTrig),
        .edgeFallTrig(edgeFallTrig),
        .irqOut(irqOut)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // The subsystem tick pulses every other cycle, so its divided clock
    // ticks every eight cycles; a pulse held two cycles would count twice.
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        subClkTick <= ~subClkTick;
        for (int i = 0; i < 8; i++)
        begin
            nRise[i] <= nRise[i] + int'(edgeRiseTrig[i] === 1'b1);
            nFall[i] <= nFall[i] + int'(edgeFallTrig[i] === 1'b1);
        end
    end

    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic isWr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        apbReq <= '{1'b1, 1'b0, isWr, a, wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (apbRsp.pready !== 1'b1 && k < 50);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        if (k >= 50)
        begin
            n_errors++;
            stop_test();
        end
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
        input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
        check(32'(e), 32'(expErr));
    endtask

    // Cycles waited go to n, and the spacing from the previous toggle seen
    // on that channel goes to gap; toggles missed while busy are not seen.
    // A quiet wait may run out without failing; any other wait that runs out fails.
    task automatic waitTog(input int ch, input int lim,
        input bit quiet = 1'b0);
        logic w;
        w = channelWaveOutput[ch];
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (channelWaveOutput[ch] === w && n < lim);
        if (!quiet && channelWaveOutput[ch] === w)
        begin
            n_errors++;
            stop_test();
        end
        gap = cyc - lastTog[ch];
        lastTog[ch] = cyc;
    endtask

    task automatic period(input int ch, input int exp);
        waitTog(ch, 200);
        waitTog(ch, 200);
        check(32'(gap), 32'(exp));
    endtask

    task automatic edgeChk(input int ch, input int er, input int ef);
        int r0;
        int f0;
        r0 = nRise[ch];
        f0 = nFall[ch];
        repeat (24) @(posedge clk_sys);
        check(32'(nRise[ch] - r0), 32'(er));
        check(32'(nFall[ch] - f0), 32'(ef));
    endtask

    initial
    begin
        rst_n = 1'b0;
        apbReq = '0;
        channelInputPin = 7'h00;
        linRxIn = 1'b0;
        auxInput7 = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(IST_OFS_RELOAD0, 32'h0000_0000, 1'b0);
        rdc(IST_OFS_DIVA, 32'h0000_0000, 1'b0);
        rdc(IST_OFS_START, 32'h0000_0000, 1'b0);
        rdc(8'h74, 32'h0000_0000, 1'b1);
        wr(IST_OFS_IRQEN, 32'h0000_0001);
        wr(IST_OFS_RELOAD0, 32'h0000_0002);
        wr(IST_OFS_START, 32'h0000_0001);
        waitTog(0, 20);
        check(32'(n), 32'h0000_0004);
        check(32'(irqOut), 32'h0000_0001);
        period(0, 3);
        period(0, 3);
        rdc(IST_OFS_IRQSTAT, 32'h0000_0001, 1'b0);
        wr(IST_OFS_IRQEN, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        check(32'(irqOut), 32'h0000_0000);
        wr(IST_OFS_MODE, 32'h0000_0002);
        wr(IST_OFS_RELOAD0 + 8'h04, 32'h0000_0002);
        wr(IST_OFS_START, 32'h0000_0002);
        waitTog(1, 20);
        check(32'(n), 32'h0000_0001);
        period(1, 3);
        wr(IST_OFS_DIVA, 32'h0000_0001);
        wr(IST_OFS_RELOAD0, 32'h0000_0009);
        period(0, 20);
        // The new reload lands mid-period, so the running period keeps 20.
        wr(IST_OFS_RELOAD0, 32'h0000_0004);
        waitTog(0, 60);
        check(32'(gap), 32'h0000_0014);
        waitTog(0, 60);
        check(32'(gap), 32'h0000_000A);
        wr(IST_OFS_STOP, 32'h0000_00FF);
        wr(IST_OFS_IRQCLR, 32'h0000_00FF);
        rdc(IST_OFS_IRQSTAT, 32'h0000_0000, 1'b0);
        rdc(IST_OFS_ENSTAT, 32'h0000_0000, 1'b0);
        waitTog(0, 40, 1'b1);
        check(32'(n), 32'h0000_0028);
        wr(IST_OFS_CLKSEL, 32'h0000_0180);
        wr(IST_OFS_DIVB, 32'h0000_0002);
        wr(IST_OFS_RELOAD0 + 8'h0C, 32'h0000_0001);
        wr(IST_OFS_RELOAD0 + 8'h10, 32'h0000_0000);
        wr(IST_OFS_START, 32'h0000_0018);
        period(3, 16);
        period(4, 3);
        rdc(IST_OFS_IRQSTAT, 32'h0000_0018, 1'b0);
        wr(IST_OFS_START, 32'h0000_0084);
        channelInputPin[2] <= 1'b1;
        edgeChk(2, 1, 0);
        channelInputPin[2] <= 1'b0;
        edgeChk(2, 0, 1);
        auxInput7 <= 1'b1;
        edgeChk(7, 0, 0);
        linRxIn <= 1'b1;
        edgeChk(7, 1, 0);
        wr(IST_OFS_ISC, 32'h0000_0001);
        auxInput7 <= 1'b0;
        edgeChk(7, 0, 1);
        stop_test();
    end
endmodule
`default_nettype wire
